// >>> hw/tsec_event_ctrl.sv
// two-stage event controller: peripheral routing stage and core event stage
// assumes the core presents accept/return strobes on the same clock and
// drives i_supervisor from its current operating mode
`timescale 1ns/1ps
`include "tsec_regs.svh"

// Notes on behaviour
// - several handlers may be active at once; higher ones interrupt lower ones
// - the highest-priority outstanding event is always dispatched first
// - levels run 0 highest to 15 lowest, level 4 reserved
// - nine general levels 7 to 15 besides the dedicated events
// - nonmaskable event comes from watchdog expiry or the external pin
// - each level keeps a return address; return restores it
// - writable assignment registers route each source to a general level
// - reset routing: errors level 7 through watchdog level 13
// - core latch, mask and pending registers, sixteen bits each
// - latch sets on capture, clears on accept; writes only where mask bit clear
// - set mask bit enables service; mask accessible in supervisor mode only
// - global enable and disable of general levels by two instructions
// - pending bit set while event active or nested; read-only, supervisor
// - peripheral mask, status and wakeup-enable registers, 32 bits each
// - set peripheral mask bit lets the source reach the core stage
// - status bit reads one while its source asserts its request
// - enabled source request while core idle wakes the processor
// - pending bits serve as acknowledgement for shared-level requests
// - general latch set on a rising edge, detection takes two cycles
// - after pending sets and latch clears, a further edge is queued
// - edge to pending takes at least three core cycles
module tsec_event_ctrl
  import tsec_pkg::*;
#(
  parameter int NUM_SRC = `TSEC_NUM_SRC,
  parameter int ADDR_W  = `TSEC_ADDR_W
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_clk_en,
  input  wire logic [NUM_SRC-1:0]          i_periph_irq,
  input  wire logic                        i_nmi_pin,
  input  wire tsec_core_evt_t              i_core_evt,
  input  wire logic                        i_supervisor,
  input  wire tsec_reg_req_t               i_reg_req,
  output logic      [`TSEC_PER_W-1:0]      o_reg_rdata,
  input  wire logic                        i_global_irq_enable_instr,
  input  wire logic                        i_global_irq_disable_instr,
  output tsec_dispatch_t                   o_dispatch,
  input  wire logic                        i_event_ack,
  input  wire logic [ADDR_W-1:0]           i_ret_addr,
  input  wire logic                        i_event_return,
  output logic      [ADDR_W-1:0]           o_ret_addr,
  output logic                             o_ret_valid,
  output logic      [`TSEC_NUM_LEVELS-1:0] o_core_event_pending,
  input  wire logic                        i_core_idle,
  output logic                             o_wakeup
);
  localparam tsec_state_t ST_RST = '{
    latch:      `TSEC_LATCH_RST,
    mask:       `TSEC_MASK_RST,
    pend:       `TSEC_PEND_RST,
    pmask:      `TSEC_PMASK_RST,
    wake:       `TSEC_WAKE_RST,
    lvl_assign: {`TSEC_ASSIGN2_RST, `TSEC_ASSIGN1_RST, `TSEC_ASSIGN0_RST},
    default:    '0
  };

  tsec_state_t                    s_q;
  tsec_state_t                    s_d;
  logic [NUM_SRC:0]               sync_w;
  logic [`TSEC_PER_W-1:0]         src_now;
  logic [`TSEC_PER_W-1:0]         src_edge;
  logic [`TSEC_NUM_GEN-1:0]       gen_edge;
  logic [`TSEC_NUM_GEN-1:0]       ack_gen;
  logic [`TSEC_NUM_LEVELS-1:0]    cin;
  logic [`TSEC_NUM_LEVELS-1:0]    rise;
  logic [`TSEC_NUM_LEVELS-1:0]    latch_n;
  logic [`TSEC_NUM_LEVELS-1:0]    pend_n;
  logic [`TSEC_NUM_LEVELS-1:0]    eff_mask;
  logic [`TSEC_NUM_LEVELS-1:0]    cand;
  logic [`TSEC_LVL_W:0]           cand_first;
  logic [`TSEC_LVL_W:0]           pend_first;
  logic [`TSEC_ASSIGN_W-1:0]      code;
  logic                           wr_ok;
  logic                           rd_ok;
  logic                           accept;
  logic                           ret_rd;

  // lowest set index wins: {found, index}
  function automatic logic [`TSEC_LVL_W:0] first_set(input logic [`TSEC_NUM_LEVELS-1:0] v);
    logic [`TSEC_LVL_W:0] r;
    r = '0;
    for (int i = `TSEC_NUM_LEVELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, `TSEC_LVL_W'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [`TSEC_ASSIGN_W-1:0] assign_code(
    input logic [`TSEC_NUM_ASSIGN-1:0][`TSEC_PER_W-1:0] a,
    input int                                             s
  );
    return a[s / `TSEC_SRC_PER_ASSIGN][(s % `TSEC_SRC_PER_ASSIGN) * `TSEC_ASSIGN_W +: `TSEC_ASSIGN_W];
  endfunction

  // peripheral requests and the external nmi pin come from outside this clock
  tsec_sync #(
    .W (NUM_SRC + 1)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_clk_en  (i_clk_en),
    .i_async   ({i_nmi_pin, i_periph_irq}),
    .o_sync    (sync_w)
  );

  assign accept = i_event_ack && s_q.disp.valid;
  assign pend_first = first_set(s_q.pend);
  assign ret_rd = i_event_return && pend_first[`TSEC_LVL_W];

  // return address saved at accept and read back on return
  tsec_ret_mem #(
    .DW    (ADDR_W),
    .DEPTH (`TSEC_NUM_LEVELS),
    .AW    (`TSEC_LVL_W)
  ) u_ret_mem (
    .i_clk_sys (i_clk_sys),
    .i_clk_en  (i_clk_en),
    .i_we      (accept),
    .i_waddr   (s_q.disp.level),
    .i_wdata   (i_ret_addr),
    .i_re      (ret_rd),
    .i_raddr   (pend_first[`TSEC_LVL_W-1:0]),
    .o_rdata   (o_ret_addr)
  );

  always_comb begin
    s_d = s_q;

    // system stage: masked source edges routed to general levels
    src_now  = `TSEC_PER_W'(sync_w[NUM_SRC-1:0]);
    src_edge = src_now & ~s_q.src_q & s_q.pmask;
    s_d.src_q = src_now;
    gen_edge = '0;
    code     = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      code = assign_code(s_q.lvl_assign, s);
      if (src_edge[s] && (code < `TSEC_ASSIGN_W'(`TSEC_NUM_GEN))) begin
        gen_edge[code] = 1'b1;
      end
    end

    // a pending bit rising is the acknowledgement for the shared level; a
    // request landing in the ack cycle is replayed one cycle later so the
    // core still sees a fresh rising edge
    ack_gen    = s_q.pend[`TSEC_NUM_LEVELS-1:`TSEC_GEN_FIRST] & ~s_q.pend_q[`TSEC_NUM_LEVELS-1:`TSEC_GEN_FIRST];
    s_d.pend_q = s_q.pend;
    s_d.hold   = ((s_q.hold | gen_edge) & ~ack_gen) | s_q.retry;
    s_d.retry  = gen_edge & ack_gen;

    s_d.wakeup = i_core_idle && ((src_now & s_q.wake) != '0);

    // core stage inputs, level 4 reserved and never raised
    cin = {s_q.hold, i_core_evt.timer, i_core_evt.hwerr, 1'b0, i_core_evt.exc,
           sync_w[NUM_SRC] | i_core_evt.wdog_nmi,
           i_core_evt.rst, i_core_evt.emulation_event};
    // edge detect: registered level, then compare with its previous value
    s_d.cin_q    = cin;
    s_d.cin_prev = s_q.cin_q;
    rise         = s_q.cin_q & ~s_q.cin_prev;

    if (i_global_irq_enable_instr) begin
      s_d.gen_en = 1'b1;
    end else if (i_global_irq_disable_instr) begin
      s_d.gen_en = 1'b0;
    end

    // register port: every register here is supervisor only
    wr_ok   = i_reg_req.wr && i_supervisor;
    rd_ok   = i_reg_req.rd && i_supervisor;
    latch_n = s_q.latch;
    pend_n  = s_q.pend;
    if (wr_ok) begin
      unique case (i_reg_req.sel)
        `TSEC_SEL_LATCH: begin
          // only bits whose mask is clear take the written value
          latch_n = (s_q.latch & s_q.mask) | (i_reg_req.wdata[`TSEC_NUM_LEVELS-1:0] & ~s_q.mask);
        end
        `TSEC_SEL_MASK: begin
          s_d.mask = i_reg_req.wdata[`TSEC_NUM_LEVELS-1:0] | `TSEC_NONMASKABLE;
        end
        `TSEC_SEL_PMASK:   s_d.pmask = i_reg_req.wdata;
        `TSEC_SEL_WAKE:    s_d.wake  = i_reg_req.wdata;
        `TSEC_SEL_ASSIGN0: s_d.lvl_assign[0] = i_reg_req.wdata;
        `TSEC_SEL_ASSIGN1: s_d.lvl_assign[1] = i_reg_req.wdata;
        `TSEC_SEL_ASSIGN2: s_d.lvl_assign[2] = i_reg_req.wdata;
        default: begin
        end
      endcase
    end

    // return leaves the innermost active level; outer ones stay pending
    if (ret_rd) begin
      pend_n[pend_first[`TSEC_LVL_W-1:0]] = 1'b0;
    end
    // accept: pending set, latch cleared, so the next edge can queue
    if (accept) begin
      pend_n[s_q.disp.level]  = 1'b1;
      latch_n[s_q.disp.level] = 1'b0;
    end
    // capture wins over any clear in the same cycle
    latch_n = latch_n | rise;
    latch_n[`TSEC_LVL_RSVD] = 1'b0;
    s_d.latch = latch_n;
    s_d.pend  = pend_n;

    // dispatch only what outranks the innermost active level
    eff_mask   = (s_q.mask | `TSEC_NONMASKABLE) & (s_q.gen_en ? '1 : ~`TSEC_GEN_BITS);
    cand       = s_q.latch & eff_mask;
    cand_first = first_set(cand);
    // the registered dispatch stage gives the third cycle of latency
    s_d.disp.valid = cand_first[`TSEC_LVL_W] && !accept &&
                     (!pend_first[`TSEC_LVL_W] || (cand_first[`TSEC_LVL_W-1:0] < pend_first[`TSEC_LVL_W-1:0]));
    s_d.disp.level = cand_first[`TSEC_LVL_W-1:0];

    s_d.ret_valid = ret_rd;

    s_d.rdata = '0;
    if (rd_ok) begin
      unique case (i_reg_req.sel)
        `TSEC_SEL_LATCH:   s_d.rdata = `TSEC_PER_W'(s_q.latch);
        `TSEC_SEL_MASK:    s_d.rdata = `TSEC_PER_W'(s_q.mask);
        `TSEC_SEL_PEND:    s_d.rdata = `TSEC_PER_W'(s_q.pend);
        `TSEC_SEL_PMASK:   s_d.rdata = s_q.pmask;
        `TSEC_SEL_PSTAT:   s_d.rdata = src_now;
        `TSEC_SEL_WAKE:    s_d.rdata = s_q.wake;
        `TSEC_SEL_ASSIGN0: s_d.rdata = s_q.lvl_assign[0];
        `TSEC_SEL_ASSIGN1: s_d.rdata = s_q.lvl_assign[1];
        `TSEC_SEL_ASSIGN2: s_d.rdata = s_q.lvl_assign[2];
        default: begin
        end
      endcase
    end
  end

  // reset routing loaded from the ST_RST local constant
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= ST_RST;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_reg_rdata          = s_q.rdata;
  assign o_dispatch           = s_q.disp;
  assign o_ret_valid          = s_q.ret_valid;
  assign o_core_event_pending = s_q.pend;
  assign o_wakeup             = s_q.wakeup;
endmodule

// >>> hw/tsec_pkg.sv
// types shared by the event controller modules
// assumes tsec_regs.svh is on the include path
package tsec_pkg;
  `include "tsec_regs.svh"

  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [3:0]              sel;
    logic [`TSEC_PER_W-1:0]  wdata;
  } tsec_reg_req_t;

  typedef struct packed {
    logic emulation_event;
    logic rst;
    logic wdog_nmi;
    logic exc;
    logic hwerr;
    logic timer;
  } tsec_core_evt_t;

  typedef struct packed {
    logic                    valid;
    logic [`TSEC_LVL_W-1:0]  level;
  } tsec_dispatch_t;

  typedef struct packed {
    logic [`TSEC_NUM_LEVELS-1:0]                     latch;
    logic [`TSEC_NUM_LEVELS-1:0]                     mask;
    logic [`TSEC_NUM_LEVELS-1:0]                     pend;
    logic [`TSEC_NUM_LEVELS-1:0]                     pend_q;
    logic [`TSEC_NUM_LEVELS-1:0]                     cin_q;
    logic [`TSEC_NUM_LEVELS-1:0]                     cin_prev;
    logic                                            gen_en;
    logic [`TSEC_PER_W-1:0]                          pmask;
    logic [`TSEC_PER_W-1:0]                          wake;
    logic [`TSEC_NUM_ASSIGN-1:0][`TSEC_PER_W-1:0]    lvl_assign;
    logic [`TSEC_PER_W-1:0]                          src_q;
    logic [`TSEC_NUM_GEN-1:0]                        hold;
    logic [`TSEC_NUM_GEN-1:0]                        retry;
    logic [`TSEC_PER_W-1:0]                          rdata;
    logic                                            wakeup;
    logic                                            ret_valid;
    tsec_dispatch_t                                  disp;
  } tsec_state_t;
endpackage

// >>> hw/tsec_regs.svh
// constants for the two-stage event controller: levels, register selects,
// reset values and timing counts; included by the package and the modules
`ifndef TSEC_REGS_SVH
`define TSEC_REGS_SVH

`define TSEC_NUM_LEVELS     16
`define TSEC_LVL_W          4
`define TSEC_LVL_EMU        4'h0
`define TSEC_LVL_RST        4'h1
`define TSEC_LVL_NMI        4'h2
`define TSEC_LVL_EXC        4'h3
`define TSEC_LVL_RSVD       4'h4
`define TSEC_LVL_HWERR      4'h5
`define TSEC_LVL_TIMER      4'h6
`define TSEC_GEN_FIRST      7
`define TSEC_NUM_GEN        9
`define TSEC_PER_W          32
`define TSEC_NUM_SRC        24
`define TSEC_ASSIGN_W       4
`define TSEC_SRC_PER_ASSIGN 8
`define TSEC_NUM_ASSIGN     3
`define TSEC_ADDR_W         32

// register selects on the core-side register port
`define TSEC_SEL_LATCH      4'h0
`define TSEC_SEL_MASK       4'h1
`define TSEC_SEL_PEND       4'h2
`define TSEC_SEL_PMASK      4'h3
`define TSEC_SEL_PSTAT      4'h4
`define TSEC_SEL_WAKE       4'h5
`define TSEC_SEL_ASSIGN0    4'h6
`define TSEC_SEL_ASSIGN1    4'h7
`define TSEC_SEL_ASSIGN2    4'h8

// fixed masks and reset values
`define TSEC_NONMASKABLE    16'h001f
`define TSEC_GEN_BITS       16'hff80
`define TSEC_LATCH_RST      16'h0000
`define TSEC_MASK_RST       16'h001f
`define TSEC_PEND_RST       16'h0000
`define TSEC_PMASK_RST      32'h0000_0000
`define TSEC_WAKE_RST       32'h0000_0000
`define TSEC_ASSIGN0_RST    32'h1000_0000
`define TSEC_ASSIGN1_RST    32'h3332_2221
`define TSEC_ASSIGN2_RST    32'h6665_5444

// timing: edge detection and least edge-to-pending latency, core cycles
`define TSEC_EDGE_CYCLES    2
`define TSEC_MIN_LAT_CYCLES 3

`endif

// >>> hw/tsec_ret_mem.sv
// return-address store, one word per event level, registered read
// assumes one write and one read port on the core clock
`timescale 1ns/1ps
module tsec_ret_mem #(
  parameter int DW    = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_clk_en,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_re,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rdata_q;

  // no reset on the array: contents are only meaningful after a write
  always_ff @(posedge i_clk_sys) begin
    if (i_clk_en) begin
      if (i_we) begin
        mem_q[i_waddr] <= i_wdata;
      end
      if (i_re) begin
        rdata_q <= mem_q[i_raddr];
      end
    end
  end

  assign o_rdata = rdata_q;
endmodule

// >>> hw/tsec_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
// assumes each bit is an independent level; no bus coherency is kept
`timescale 1ns/1ps
module tsec_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  input  wire logic         i_clk_en,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } tsec_sync_st_t;

  tsec_sync_st_t s_q;
  tsec_sync_st_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.meta   = i_async;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.stable;
endmodule

// >>> verif/testbench.sv
// self-checking bench: register table, dedicated events, routing, nesting
// assumes the core model on the dispatch side and the bound checker
`timescale 1ns/1ps
`include "tsec_regs.svh"
module testbench;
  import tsec_pkg::*;
  typedef struct { logic [3:0] sel; logic [31:0] exp; } tsec_row_t;
  logic           i_clk_sys, i_reset_n, nmi, sup, gen_on, gen_off, ack, ret, idle, ret_vld, wake;
  logic [23:0]    irq;
  logic [6:0]     ev;
  logic [3:0]     delay;
  logic [31:0]    rdata, ret_in, ret_out, rv;
  logic [15:0]    pend;
  tsec_core_evt_t cevt;
  tsec_reg_req_t  req;
  tsec_dispatch_t disp;
  int             miscompares, checks, cycles, n;
  logic [3:0]     lv [7] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h5, 4'h6};
  tsec_row_t      rows [10] = '{'{4'h0, 32'h0}, '{4'h1, 32'h1f}, '{4'h2, 32'h0}, '{4'h3, 32'h0},
    '{4'h4, 32'h0}, '{4'h5, 32'h0}, '{4'h6, 32'h1000_0000}, '{4'h7, 32'h3332_2221},
    '{4'h8, 32'h6665_5444}, '{4'h9, 32'h0}};
  assign cevt = '{emulation_event: ev[0], rst: ev[1], wdog_nmi: ev[2], exc: ev[4], hwerr: ev[5], timer: ev[6]};
  tsec_event_ctrl i_tsec_event_ctrl (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_clk_en(1'b1), .i_periph_irq(irq),
    .i_nmi_pin(ev[3]), .i_core_evt(cevt), .i_supervisor(sup), .i_reg_req(req), .o_reg_rdata(rdata),
    .i_global_irq_enable_instr(gen_on), .i_global_irq_disable_instr(gen_off), .o_dispatch(disp),
    .i_event_ack(ack), .i_ret_addr(ret_in), .i_event_return(ret), .o_ret_addr(ret_out),
    .o_ret_valid(ret_vld), .o_core_event_pending(pend), .i_core_idle(idle), .o_wakeup(wake));
  tsec_core_model i_tsec_core_model (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_dispatch(disp),
    .i_delay(delay), .o_event_ack(ack), .o_ret_addr(ret_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] s, input logic [31:0] d);
    req = '{1'b1, 1'b0, s, d};
    cyc(1);
    req = '0;
  endtask
  task automatic reg_rd(input logic [3:0] s, output logic [31:0] d);
    req = '{1'b0, 1'b1, s, 32'h0};
    cyc(1);
    req = '0;
    d = rdata;
  endtask
  task automatic wait_pend(input int b);
    n = 0;
    while (pend[b] !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk({31'h0, pend[b]}, 32'h1);
  endtask
  task automatic do_ret(input logic [31:0] a, input logic [15:0] p);
    ret = 1'b1;
    cyc(1);
    ret = 1'b0;
    chk(ret_out, a);
    chk({ret_vld, pend}, {1'b1, p});
  endtask
  task automatic results();
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    i_reset_n = 1'b0;
    {irq, ev, sup, gen_on, gen_off, ret, idle, req} = '0;
    delay = 4'h0;
    cyc(6);
    i_reset_n = 1'b1;
    sup = 1'b1;
    foreach (rows[i]) begin
      reg_rd(rows[i].sel, rv);
      chk(rv, rows[i].exp);
    end
    sup = 1'b0;
    reg_wr(`TSEC_SEL_PMASK, 32'hffff_ffff);
    reg_rd(`TSEC_SEL_PMASK, rv);
    chk(rv, 32'h0);
    sup = 1'b1;
    reg_wr(`TSEC_SEL_MASK, 32'hffe0);
    reg_rd(`TSEC_SEL_MASK, rv);
    chk(rv, 32'hffff);
    reg_wr(`TSEC_SEL_LATCH, 32'h0200);
    reg_rd(`TSEC_SEL_LATCH, rv);
    chk(rv, 32'h0);
    foreach (lv[i]) begin
      ev = 7'h1 << i;
      wait_pend(lv[i]);
      chk({16'h0, pend}, 32'h1 << lv[i]);
      ev = 7'h0;
      do_ret({28'ha000_000, lv[i]}, 16'h0);
    end
    irq[0] = 1'b1;
    irq[7] = 1'b1;
    cyc(6);
    reg_rd(`TSEC_SEL_PSTAT, rv);
    chk(rv, 32'h81);
    reg_rd(`TSEC_SEL_LATCH, rv);
    chk({rv[15:0], pend}, 32'h0);
    irq = '0;
    reg_wr(`TSEC_SEL_PMASK, 32'h83);
    gen_on = 1'b1;
    cyc(4);
    gen_on = 1'b0;
    irq[0] = 1'b1;
    wait_pend(7);
    chk({31'h0, n >= 3}, 32'h1);
    irq[7] = 1'b1;
    cyc(10);
    chk({disp.valid, pend}, {1'b0, 16'h80});
    delay = 4'h5;
    ev = 7'h40;
    wait_pend(6);
    chk({16'h0, pend}, 32'hc0);
    ev = 7'h0;
    do_ret(32'ha000_0006, 16'h80);
    cyc(1);
    do_ret(32'ha000_0007, 16'h0);
    wait_pend(8);
    irq[7] = 1'b0;
    cyc(4);
    irq[7] = 1'b1;
    cyc(6);
    reg_rd(`TSEC_SEL_LATCH, rv);
    chk(rv, 32'h0100);
    do_ret(32'ha000_0008, 16'h0);
    wait_pend(8);
    do_ret(32'ha000_0008, 16'h0);
    irq = '0;
    gen_off = 1'b1;
    cyc(4);
    gen_off = 1'b0;
    irq[0] = 1'b1;
    cyc(10);
    reg_rd(`TSEC_SEL_LATCH, rv);
    chk({rv[15:0], pend}, 32'h0080_0000);
    gen_on = 1'b1;
    cyc(1);
    gen_on = 1'b0;
    wait_pend(7);
    reg_rd(`TSEC_SEL_LATCH, rv);
    chk(rv, 32'h0);
    do_ret(32'ha000_0007, 16'h0);
    irq = '0;
    cyc(4);
    // source 0 moves to level 9; peripherals stay on levels 7 to 13; software levels 14 and 15 left free
    reg_wr(`TSEC_SEL_ASSIGN0, 32'h1000_0002);
    irq[0] = 1'b1;
    wait_pend(9);
    chk({16'h0, pend}, 32'h0200);
    do_ret(32'ha000_0009, 16'h0);
    reg_wr(`TSEC_SEL_WAKE, 32'h1);
    idle = 1'b1;
    cyc(4);
    chk({31'h0, wake}, 32'h1);
    idle = 1'b0;
    cyc(2);
    chk({31'h0, wake}, 32'h0);
    i_reset_n = 1'b0;
    cyc(2);
    i_reset_n = 1'b1;
    reg_rd(`TSEC_SEL_MASK, rv);
    chk({rv[15:0], pend}, 32'h001f_0000);
    results();
  end
endmodule

bind tsec_event_ctrl tsec_event_ctrl_props #(.NUM_SRC(NUM_SRC), .ADDR_W(ADDR_W)) i_props (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_supervisor(i_supervisor),
  .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .o_dispatch(o_dispatch), .i_event_ack(i_event_ack),
  .i_event_return(i_event_return), .o_ret_valid(o_ret_valid), .o_core_event_pending(o_core_event_pending),
  .i_core_idle(i_core_idle), .o_wakeup(o_wakeup));

// >>> verif/tsec_core_model.sv
// behavioural core on the dispatch side: accepts after a set delay
// assumes the controller's clock; delay 0 answers on the first clock edge after dispatch
`timescale 1ns/1ps
module tsec_core_model
  import tsec_pkg::*;
(
  input  wire logic           i_clk_sys,
  input  wire logic           i_reset_n,
  input  wire tsec_dispatch_t i_dispatch,
  input  wire logic [3:0]     i_delay,
  output logic                o_event_ack,
  output logic [31:0]         o_ret_addr
);
  logic [3:0] wait_q;
  // address encodes the level so each return can be traced to its entry
  assign o_ret_addr = {28'ha000_000, i_dispatch.level};
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_q      <= 4'h0;
      o_event_ack <= 1'b0;
    end else begin
      o_event_ack <= i_dispatch.valid && !o_event_ack && wait_q >= i_delay;
      wait_q      <= (i_dispatch.valid && !o_event_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

// >>> verif/tsec_event_ctrl_props.sv
// port-level checks on the two-stage event controller
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/1ps
`include "tsec_regs.svh"
module tsec_event_ctrl_props
  import tsec_pkg::*;
#(
  parameter int NUM_SRC = `TSEC_NUM_SRC,
  parameter int ADDR_W  = `TSEC_ADDR_W
) (
  input wire logic                        i_clk_sys,
  input wire logic                        i_reset_n,
  input wire logic                        i_clk_en,
  input wire logic                        i_supervisor,
  input wire tsec_reg_req_t               i_reg_req,
  input wire logic [`TSEC_PER_W-1:0]      o_reg_rdata,
  input wire tsec_dispatch_t              o_dispatch,
  input wire logic                        i_event_ack,
  input wire logic                        i_event_return,
  input wire logic                        o_ret_valid,
  input wire logic [`TSEC_NUM_LEVELS-1:0] o_core_event_pending,
  input wire logic                        i_core_idle,
  input wire logic                        o_wakeup
);
  logic [15:0] prev_q;
  logic [15:0] fresh;
  // bits that rose this cycle; a held bit must not be mistaken for a new accept
  assign fresh = o_core_event_pending & ~prev_q;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_q <= 16'h0;
    end else begin
      prev_q <= o_core_event_pending;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  rdata_idle_a:
    assert property (i_clk_en && !(i_reg_req.rd && i_supervisor) |=> o_reg_rdata == 32'h0)
    else $error("read data not zero without a supervisor read");
  mask_fixed_a:
    assert property (i_clk_en && i_reg_req.rd && i_supervisor && i_reg_req.sel == `TSEC_SEL_MASK
                     |=> o_reg_rdata[4:0] == 5'h1f && o_reg_rdata[31:16] == 16'h0)
    else $error("mask read lost fixed bits");
  dispatch_prio_a:
    assert property (o_dispatch.valid
                     |-> (o_core_event_pending & ((16'h2 << o_dispatch.level) - 16'h1)) == 16'h0)
    else $error("dispatch not above innermost active level");
  accept_a:
    assert property (i_clk_en && o_dispatch.valid && i_event_ack && !i_event_return
                     |=> !o_dispatch.valid ##0 o_core_event_pending[$past(o_dispatch.level)])
    else $error("accept did not set pending");
  pend_cause_a:
    assert property (fresh != 16'h0 |-> $past(o_dispatch.valid) && $past(i_event_ack)
                     && fresh == (16'h1 << $past(o_dispatch.level)))
    else $error("pending bit rose without accept");
  level_four_a:
    assert property (!(o_dispatch.valid && o_dispatch.level == `TSEC_LVL_RSVD) && !o_core_event_pending[4])
    else $error("reserved level used");
  ret_pulse_a:
    assert property (o_ret_valid |-> $past(i_event_return))
    else $error("return valid without return");
  ret_clear_a:
    assert property (i_clk_en && i_event_return && o_core_event_pending != 16'h0
                     && !(o_dispatch.valid && i_event_ack) |=> o_ret_valid
                     && o_core_event_pending == ($past(o_core_event_pending) & ($past(o_core_event_pending) - 16'h1)))
    else $error("return did not clear innermost level");
  wake_idle_a:
    assert property (o_wakeup |-> $past(i_core_idle))
    else $error("wakeup while core busy");
endmodule
